// File: fdcotr_cfg.svh
`ifndef FDCOTR_CFG_SVH
`define FDCOTR_CFG_SVH

// register byte offsets on the apb bus
`define FDCOTR_OFF_DIAG 12'h000
`define FDCOTR_OFF_DOC 12'h004
`define FDCOTR_OFF_TAPE 12'h008
`define FDCOTR_OFF_CFG 12'h00c

// reset values
`define FDCOTR_DOC_RESET 8'h00
`define FDCOTR_TAPE_RESET 4'h0
`define FDCOTR_CFG_RESET 6'h10
`define FDCOTR_PIN_RESET 8'h03

// drive_output_control field positions
`define FDCOTR_DOC_MOTOR_LSB 4
`define FDCOTR_DOC_DMA_BIT 3
`define FDCOTR_DOC_RST_BIT 2

// tape_media_assign field positions
`define FDCOTR_TAPE_SWAP_LSB 2

// controller reset low time
`define FDCOTR_CLK_PERIOD_NS 10
`define FDCOTR_RST_MIN_NS 100
`define FDCOTR_RST_MIN_CYC ((`FDCOTR_RST_MIN_NS + `FDCOTR_CLK_PERIOD_NS - 1) / `FDCOTR_CLK_PERIOD_NS)

`endif

// File: fdcotr_drive_model.sv
`default_nettype none
// behavioural drives; a disc spins in drive 0 while its motor runs
module fdcotr_drive_model
    import fdcotr_pkg::*;
(
    input wire logic pclk,
    input wire logic [3:0] drive_select_n,
    input wire logic [3:0] motor_on_n,
    input wire logic [1:0] media_in,
    output fdcotr_pins_type pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph = 3'h0;
    // read pulses four cycles wide so the pin filter keeps them
    always @(posedge pclk) begin
        ph <= ph + 3'h1;
    end
    // media_in marks which drives hold a disc
    always_comb begin
        pins.drive_ident_1 = media_in[1];
        pins.drive_ident_0 = ~media_in[0];
        pins.media_valid_1 = ~media_in[1];
        pins.media_valid_0 = ~media_in[0];
        pins.media_sense_high = 1'b1;
        pins.media_sense_low = drive_select_n[0]; // high density disc in drive 0
        pins.read_data_n = motor_on_n[0] | ph[2];
        pins.second_drive_installed_n = 1'b0;
    end
endmodule : fdcotr_drive_model
`default_nettype wire

// File: fdcotr_pkg.sv
`default_nettype none
package fdcotr_pkg;
    // host register mode
    typedef enum logic [1:0] {
        FDCOTR_LEGACY = 2'b00,
        FDCOTR_EXTENDED = 2'b01,
        FDCOTR_COMPACT = 2'b10
    } fdcotr_host_type;

    // tape register mode
    typedef enum logic [1:0] {
        FDCOTR_TAPE_COMPAT = 2'b00,
        FDCOTR_TAPE_SENSE = 2'b01,
        FDCOTR_TAPE_ENH = 2'b10
    } fdcotr_tape_mode_type;

    // configuration register, bit 5 down to 0
    typedef struct packed {
        logic asc_enhanced;
        logic fcr_compat;
        logic fcr_swap01;
        logic four_drive;
        fdcotr_host_type host_mode;
    } fdcotr_cfg_type;

    // drive interface pins, bit 7 down to 0
    typedef struct packed {
        logic drive_ident_1;
        logic drive_ident_0;
        logic media_valid_1;
        logic media_valid_0;
        logic media_sense_high;
        logic media_sense_low;
        logic read_data_n;
        logic second_drive_installed_n;
    } fdcotr_pins_type;
endpackage : fdcotr_pkg
`default_nettype wire

// File: fdcotr_regs.sv
// Design decisions made here: the placing of the registers and the APB register port.
`default_nettype none
`include "fdcotr_cfg.svh"

module fdcotr_regs
    import fdcotr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fdcotr_pins_type pins,
    input wire logic write_data_n,
    input wire logic write_gate_out,
    input wire logic input_reg_read,
    output logic [3:0] drive_select_n,
    output logic shared_drive_select_2_3_n,
    output logic [3:0] motor_on_n,
    output logic dma_irq_gate,
    output logic ctrl_reset_n,
    output logic [1:0] tape_drive_assign
);
    localparam logic [7:0] pin_rst = `FDCOTR_PIN_RESET;
    localparam logic [3:0] rst_min = 4'(`FDCOTR_RST_MIN_CYC);

    // address decode: {hit, index}
    function automatic logic [2:0] fdcotr_decode(input logic [11:0] addr);
        logic [2:0] res;
        res = 3'h0;
        if (addr == `FDCOTR_OFF_DIAG) begin
            res = 3'h4;
        end else if (addr == `FDCOTR_OFF_DOC) begin
            res = 3'h5;
        end else if (addr == `FDCOTR_OFF_TAPE) begin
            res = 3'h6;
        end else if (addr == `FDCOTR_OFF_CFG) begin
            res = 3'h7;
        end
        return res;
    endfunction : fdcotr_decode

    logic [7:0] doc;
    logic [3:0] tape;
    fdcotr_cfg_type cfg;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] pin_q;
    fdcotr_pins_type pin_s;
    logic rdata_prev;
    logic wdata_prev;
    logic write_gate_out_prev;
    logic wdata_lat;
    logic rdata_lat;
    logic write_gate_out_lat;
    logic [3:0] rst_cnt;
    logic [2:0] dec;
    logic access;
    logic wr_en;
    fdcotr_tape_mode_type tape_mode;
    logic [3:0] ds_int;
    logic [3:0] mt_int;
    logic [3:0] next_ds;
    logic [3:0] next_mt;
    logic [7:0] diag_val;
    logic [7:0] doc_val;
    logic [7:0] tape_val;
    logic valid_bit;
    logic [7:0] rd_val;

    // pin synchronisers, value moves once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[gi] <= pin_rst[gi];
                    sync2[gi] <= pin_rst[gi];
                    sync3[gi] <= pin_rst[gi];
                    pin_q[gi] <= pin_rst[gi];
                end else begin
                    sync1[gi] <= pins[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        pin_q[gi] <= sync3[gi];
                    end
                end
            end
        end
    endgenerate
    assign pin_s = pin_q;

    // bus decode and access strobe
    assign dec = fdcotr_decode(paddr);
    assign access = psel && penable && pready;
    assign wr_en = access && pwrite && pstrb[0];

    // no wait state: ready rises in the access phase only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable && !pready;
        end
    end

    // unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && !dec[2];
        end
    end

    // drive output control, untouched by the controller soft reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            doc <= `FDCOTR_DOC_RESET;
        end else if (wr_en && dec == 3'h5) begin
            doc <= pwdata[7:0];
        end
    end

    // tape assignment and exchange bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tape <= `FDCOTR_TAPE_RESET;
        end else if (wr_en && dec == 3'h6) begin
            tape <= pwdata[3:0];
        end
    end

    // block configuration bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `FDCOTR_CFG_RESET;
        end else if (wr_en && dec == 3'h7) begin
            cfg <= pwdata[5:0];
        end
    end

    // previous levels for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_prev <= 1'b1;
            wdata_prev <= 1'b1;
            write_gate_out_prev <= 1'b0;
        end else begin
            rdata_prev <= pin_s.read_data_n;
            wdata_prev <= write_data_n;
            write_gate_out_prev <= write_gate_out;
        end
    end

    // latched diagnostics; a new edge beats the clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdata_lat <= 1'b0;
        end else if (write_data_n && !wdata_prev) begin
            wdata_lat <= 1'b1;
        end else if (input_reg_read) begin
            wdata_lat <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_lat <= 1'b0;
        end else if (pin_s.read_data_n && !rdata_prev) begin
            rdata_lat <= 1'b1;
        end else if (input_reg_read) begin
            rdata_lat <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_gate_out_lat <= 1'b0;
        end else if (write_gate_out && !write_gate_out_prev) begin
            write_gate_out_lat <= 1'b1;
        end else if (input_reg_read) begin
            write_gate_out_lat <= 1'b0;
        end
    end

    // reset stays on at least the minimum time after the bit returns high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt <= 4'h0;
        end else if (!doc[`FDCOTR_DOC_RST_BIT]) begin
            rst_cnt <= rst_min;
        end else if (rst_cnt != 4'h0) begin
            rst_cnt <= rst_cnt - 4'h1;
        end
    end

    // controller reset also clears configure and mode settings elsewhere
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reset_n <= 1'b0;
        end else begin
            ctrl_reset_n <= doc[`FDCOTR_DOC_RST_BIT] && rst_cnt == 4'h0;
        end
    end

    // tape register mode from the two configuration bits
    always_comb begin
        if (cfg.asc_enhanced) begin
            tape_mode = FDCOTR_TAPE_ENH;
        end else if (cfg.fcr_compat) begin
            tape_mode = FDCOTR_TAPE_COMPAT;
        end else begin
            tape_mode = FDCOTR_TAPE_SENSE;
        end
    end

    // internal selects; none active while the controller is held in reset
    // drive 2 is kept outside four drive mode only so exchange 10 can reach pin 0
    always_comb begin
        ds_int = 4'h0;
        if (ctrl_reset_n) begin
            ds_int[doc[1:0]] = 1'b1;
        end
        mt_int = doc[7:`FDCOTR_DOC_MOTOR_LSB];
        if (!cfg.four_drive) begin
            ds_int[3] = 1'b0;
            if (!(tape_mode == FDCOTR_TAPE_ENH && tape[3:2] == 2'b10)) begin
                ds_int[2] = 1'b0;
            end
        end
    end

    // logical drive exchange onto the physical pins
    always_comb begin
        next_ds = ds_int;
        next_mt = mt_int;
        if (tape_mode == FDCOTR_TAPE_ENH && !cfg.four_drive) begin
            case (tape[3:2])
                2'b01: begin
                    if (cfg.fcr_swap01) begin
                        next_ds = {ds_int[3:2], ds_int[0], ds_int[1]};
                        next_mt = {mt_int[3:2], mt_int[0], mt_int[1]};
                    end
                end
                2'b10: begin
                    next_ds = {ds_int[3], ds_int[0], ds_int[1], ds_int[2]};
                    next_mt = {mt_int[3], mt_int[0], mt_int[1], mt_int[2]};
                end
                default: begin
                    next_ds = ds_int;
                    next_mt = mt_int;
                end
            endcase
        end
        // motor pins 3,2 masked after the exchange, not before it
        if (!cfg.four_drive) begin
            next_mt[3:2] = 2'b00;
        end
    end

    // physical drive outputs, active low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_select_n <= 4'hf;
            shared_drive_select_2_3_n <= 1'b1;
            motor_on_n <= 4'hf;
        end else begin
            drive_select_n <= ~next_ds;
            shared_drive_select_2_3_n <= ~(next_ds[2] | next_ds[3]);
            motor_on_n <= ~next_mt;
        end
    end

    // dma and interrupt pin gate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_irq_gate <= 1'b0;
        end else if (cfg.host_mode == FDCOTR_EXTENDED) begin
            dma_irq_gate <= 1'b1;
        end else begin
            dma_irq_gate <= doc[`FDCOTR_DOC_DMA_BIT];
        end
    end

    // tape drive assignment out to the data separator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tape_drive_assign <= 2'b00;
        end else begin
            tape_drive_assign <= tape[1:0];
        end
    end

    // read values of the three host registers
    always_comb begin
        diag_val = 8'h00;
        if (cfg.host_mode == FDCOTR_COMPACT) begin
            diag_val[7] = pin_s.second_drive_installed_n;
            diag_val[6] = drive_select_n[1];
            diag_val[5] = drive_select_n[0];
            diag_val[1] = drive_select_n[3];
            diag_val[0] = drive_select_n[2];
        end
        diag_val[4] = wdata_lat;
        diag_val[3] = rdata_lat;
        diag_val[2] = write_gate_out_lat;
        doc_val = doc;
        if (cfg.host_mode == FDCOTR_EXTENDED) begin
            doc_val[`FDCOTR_DOC_DMA_BIT] = 1'b0;
        end
        if (doc[1:0] == 2'b00) begin
            valid_bit = pin_s.media_valid_0;
        end else if (doc[1:0] == 2'b01) begin
            valid_bit = pin_s.media_valid_1;
        end else begin
            valid_bit = 1'b1;
        end
        case (tape_mode)
            FDCOTR_TAPE_SENSE: begin
                tape_val = {pin_s.media_sense_high, pin_s.media_sense_low,
                    valid_bit, 3'h0, tape[1:0]};
            end
            FDCOTR_TAPE_ENH: begin
                tape_val = {pin_s.media_sense_high, pin_s.media_sense_low,
                    pin_s.drive_ident_1, pin_s.drive_ident_0, tape};
            end
            default: begin
                tape_val = {6'h00, tape[1:0]};
            end
        endcase
    end

    // read mux by decoded index
    always_comb begin
        rd_val = 8'h00;
        if (dec == 3'h4) begin
            rd_val = diag_val;
        end else if (dec == 3'h5) begin
            rd_val = doc_val;
        end else if (dec == 3'h6) begin
            rd_val = tape_val;
        end else if (dec == 3'h7) begin
            rd_val = {2'b00, cfg};
        end
    end

    // read data captured in the setup cycle, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rd_val};
        end
    end
endmodule : fdcotr_regs
`default_nettype wire

// File: fdcotr_regs_assertions.sv
`default_nettype none
`include "fdcotr_cfg.svh"
module fdcotr_regs_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [3:0] drive_select_n,
    input wire logic shared_drive_select_2_3_n,
    input wire logic [3:0] motor_on_n,
    input wire logic ctrl_reset_n,
    input wire logic [1:0] tape_drive_assign
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wr_ok;
    logic wr_doc;
    logic wr_tape;
    // a write lands only at the access edge with the low strobe set
    assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
    assign wr_doc = wr_ok && paddr == `FDCOTR_OFF_DOC;
    assign wr_tape = wr_ok && paddr == `FDCOTR_OFF_TAPE;
    property p_setup_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_setup_ready: assert property (p_setup_ready) else $error("apb answer late");
    property p_one_select;
        $countones(~drive_select_n) <= 1;
    endproperty
    a_one_select: assert property (p_one_select) else $error("two selects");
    property p_held_idle;
        !ctrl_reset_n [*2] |-> drive_select_n == 4'hf;
    endproperty
    a_held_idle: assert property (p_held_idle) else $error("select in reset");
    property p_shared;
        shared_drive_select_2_3_n == (drive_select_n[2] & drive_select_n[3]);
    endproperty
    a_shared: assert property (p_shared) else $error("shared select wrong");
    property p_rst_low;
        $fell(ctrl_reset_n) |-> !ctrl_reset_n [*8];
    endproperty
    a_rst_low: assert property (p_rst_low) else $error("reset too short");
    property p_motor_off;
        wr_doc && pwdata[7:4] == 4'h0 |-> ##2 motor_on_n == 4'hf;
    endproperty
    a_motor_off: assert property (p_motor_off) else $error("motor left on");
    property p_tape_copy;
        wr_tape |-> ##2 tape_drive_assign == $past(pwdata[1:0], 2);
    endproperty
    a_tape_copy: assert property (p_tape_copy) else $error("tape pins wrong");
    property p_reset_bit;
        wr_doc && !pwdata[2] |-> ##2 !ctrl_reset_n;
    endproperty
    a_reset_bit: assert property (p_reset_bit) else $error("no soft reset");
    c_doc: cover property (wr_doc);
    c_tape: cover property (wr_tape);
    c_soft: cover property ($fell(ctrl_reset_n));
endmodule : fdcotr_regs_checker
bind fdcotr_regs fdcotr_regs_checker fdcotr_regs_checker_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .drive_select_n,
    .shared_drive_select_2_3_n, .motor_on_n, .ctrl_reset_n, .tape_drive_assign);
`default_nettype wire

// File: floppy_ctrl_output_tape_regs_tb_top.sv
`default_nettype none
`include "fdcotr_cfg.svh"
module floppy_ctrl_output_tape_regs_tb_top
    import fdcotr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] a_diag = `FDCOTR_OFF_DIAG;
    localparam logic [11:0] a_doc = `FDCOTR_OFF_DOC;
    localparam logic [11:0] a_tape = `FDCOTR_OFF_TAPE;
    localparam logic [11:0] a_cfg = `FDCOTR_OFF_CFG;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic write_data_n = 1'b1, write_gate_out = 1'b0, input_reg_read = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [1:0] media_in = 2'b00;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, erv, dma_irq_gate, ctrl_reset_n, shared_drive_select_2_3_n;
    logic [3:0] drive_select_n, motor_on_n;
    logic [1:0] tape_drive_assign;
    fdcotr_pins_type pins;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    fdcotr_regs fdcotr_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .pins, .write_data_n,
        .write_gate_out, .input_reg_read, .drive_select_n, .shared_drive_select_2_3_n,
        .motor_on_n, .dma_irq_gate, .ctrl_reset_n, .tape_drive_assign);
    fdcotr_drive_model fdcotr_drive_model_i (.pclk, .drive_select_n, .motor_on_n,
        .media_in, .pins);
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed; pready seen high ends this wait, the hang guard bounds it
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
        apb(1'b0, a, 8'h00);
        chk(rdv & {24'h0, m}, {24'h0, e});
    endtask : rdc
    task automatic pulse_clr;
        input_reg_read <= 1'b1;
        cyc(1);
        input_reg_read <= 1'b0;
        cyc(2);
    endtask : pulse_clr
    task automatic t_reset;
        chk({motor_on_n, drive_select_n}, 8'hff);
        chk({dma_irq_gate, ctrl_reset_n}, 2'b00);
        rdc(a_doc, 8'h00, 8'hff);
        rdc(a_diag, 8'h00, 8'hff);
        wr(a_cfg, 8'h12);
        cyc(8);
        rdc(a_diag, 8'h63, 8'hff);
        apb(1'b0, 12'h010, 8'h00);
        chk({31'h0, erv}, 32'h1);
        chk(rdv, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_drives;
        logic [7:0] tbl [4] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f};
        logic [3:0] ds;
        wr(a_cfg, 8'h16);
        for (int i = 0; i < 4; i++) begin
            wr(a_doc, tbl[i]);
            cyc(14);
            ds = ~(4'h1 << i);
            chk({motor_on_n, drive_select_n}, {ds, ds});
            chk({dma_irq_gate, ctrl_reset_n}, 2'b11);
            rdc(a_diag, {1'b0, ds[1], ds[0], 3'h0, ds[3], ds[2]}, 8'he3);
        end
        wr(a_doc, 8'h04);
        cyc(3);
        chk(dma_irq_gate, 1'b0);
        // extended mode keeps dma and interrupt pins live even in reset
        wr(a_cfg, 8'h11);
        wr(a_doc, 8'h08);
        cyc(3);
        chk(dma_irq_gate, 1'b1);
        rdc(a_doc, 8'h00, 8'hff);
        wr(a_cfg, 8'h12);
        wr(a_doc, 8'h4e);
        cyc(14);
        chk({motor_on_n, drive_select_n}, 8'hff);
        $display("t_drives done");
    endtask : t_drives
    task automatic t_soft;
        int n;
        n = 0;
        wr(a_doc, 8'h1d);
        cyc(14);
        wr(a_doc, 8'h19);
        rdc(a_doc, 8'h19, 8'hff);
        chk({motor_on_n, ctrl_reset_n}, 5'h1c);
        wr(a_doc, 8'h1d);
        while (ctrl_reset_n !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk(n >= 10 && n < 40, 1'b1);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        rdc(a_doc, 8'h00, 8'hff);
        rdc(a_cfg, 8'h10, 8'hff);
        $display("t_soft done");
    endtask : t_soft
    task automatic t_latch;
        wr(a_cfg, 8'h12);
        wr(a_doc, 8'h04);
        cyc(12);
        pulse_clr();
        rdc(a_diag, 8'h00, 8'h1c);
        // write data edge with the write gate still low
        write_data_n <= 1'b0;
        cyc(1);
        write_data_n <= 1'b1;
        cyc(3);
        rdc(a_diag, 8'h10, 8'h1c);
        write_gate_out <= 1'b1;
        cyc(3);
        rdc(a_diag, 8'h14, 8'h1c);
        pulse_clr();
        rdc(a_diag, 8'h00, 8'h1c);
        write_gate_out <= 1'b0;
        wr(a_doc, 8'h14);
        cyc(20);
        rdc(a_diag, 8'h08, 8'h1c);
        wr(a_doc, 8'h04);
        cyc(12);
        pulse_clr();
        rdc(a_diag, 8'h00, 8'h1c);
        $display("t_latch done");
    endtask : t_latch
    task automatic t_tape;
        wr(a_cfg, 8'h10);
        for (int k = 0; k < 4; k++) begin
            wr(a_tape, 8'hfc | k[7:0]);
            cyc(3);
            chk(tape_drive_assign, k[1:0]);
            rdc(a_tape, k[7:0], 8'hff);
        end
        wr(a_cfg, 8'h00);
        media_in <= 2'b10;
        for (int s = 0; s < 3; s++) begin
            wr(a_doc, 8'h04 | s[7:0]);
            cyc(12);
            rdc(a_tape, {1'b1, s != 0, s != 1, 5'h03}, 8'hff);
        end
        wr(a_cfg, 8'h20);
        wr(a_tape, 8'h09);
        wr(a_doc, 8'h1c);
        cyc(12);
        chk({shared_drive_select_2_3_n, drive_select_n[0]}, 2'b01);
        rdc(a_tape, 8'hf9, 8'hff);
        wr(a_doc, 8'h4e);
        cyc(12);
        chk({motor_on_n[0], drive_select_n[0]}, 2'b00);
        wr(a_cfg, 8'h28);
        wr(a_tape, 8'h05);
        wr(a_doc, 8'h1d);
        cyc(12);
        chk({motor_on_n, drive_select_n}, 8'hde);
        wr(a_cfg, 8'h2c);
        cyc(4);
        chk({motor_on_n, drive_select_n}, 8'hed);
        $display("t_tape done");
    endtask : t_tape
    initial begin
        forever #5 pclk = ~pclk;
    end
    // hang guard, well above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_drives();
        t_soft();
        t_latch();
        t_tape();
        print_verdict();
    end
endmodule : floppy_ctrl_output_tape_regs_tb_top
`default_nettype wire
